// File: verilog/rpx_defs.svh
// constants for the reader command and result exchange
`ifndef RPX_DEFS_SVH
`define RPX_DEFS_SVH

// ----------------------------------------
// command codes, four BCD digits
// ----------------------------------------
`define RPX_CMD_SINGLE 16'h0010
`define RPX_CMD_CONT 16'h0011
`define RPX_CMD_STOP 16'h0012
`define RPX_CMD_SCENE_SET 16'h0020
`define RPX_CMD_SCENE_INC 16'h0021
`define RPX_CMD_SCENE_DEC 16'h0022
`define RPX_CMD_SCENE_GET 16'h0023

// ----------------------------------------
// word offsets in the command and result areas
// ----------------------------------------
`define RPX_OFS_CMD 5'h00
`define RPX_OFS_ARG 5'h01
`define RPX_OFS_FLAG 5'h00
`define RPX_OFS_DATA 5'h01
`define RPX_OFS_DATA_LAST 5'h1c

// ----------------------------------------
// fields, limits and reset values
// ----------------------------------------
`define RPX_MAX_BYTES 6'h38
`define RPX_PAD_CHAR 8'h20
`define RPX_SCENE_MAX 4'h9
`define RPX_SCENE_RST 4'h0
`define RPX_FLAG_RST 4'hf
`define RPX_AREA_CMD 1'b0
`define RPX_AREA_RES 1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define RPX_CLK_MHZ 125
`define RPX_TIMEOUT_S 5

`endif

// File: verilog/rpx_pkg.sv
// types for the reader command and result exchange
package rpx_pkg;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [6:0] {
    ST_POLL   = 7'b0000001,
    ST_ARG    = 7'b0000010,
    ST_DECODE = 7'b0000100,
    ST_FETCH  = 7'b0001000,
    ST_LOAD   = 7'b0010000,
    ST_WRITE  = 7'b0100000,
    ST_FLAG   = 7'b1000000
  } rpx_state_t;

  typedef enum logic [2:0] {
    RK_DATA  = 3'b001,
    RK_ERR   = 3'b010,
    RK_SCENE = 3'b100
  } rpx_kind_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic req;
    logic we;
    logic area;
    logic [4:0] addr;
    logic [15:0] wdata;
  } rpx_plc_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } rpx_plc_rsp_t;

  typedef struct packed {
    logic done;
    logic ok;
    logic byte_valid;
    logic [7:0] data;
    logic [15:0] err_code;
  } rpx_dec_in_t;

endpackage

// File: verilog/rpx_result_mem.sv
// byte-lane result buffer, registered read
`timescale 1ns/100ps
module rpx_result_mem #(
  parameter int DW = 8,
  parameter int LANES = 2,
  parameter int DEPTH = 28,
  parameter int AW = 5
) (
  input wire logic mclk_i,
  input wire logic [LANES-1:0] wr_en_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wbyte_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [LANES*DW-1:0] rdata_o
);

  // ----------------------------------------
  // one array per lane, lane 0 is the high byte
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [DW-1:0] mem [DEPTH];
      always_ff @(posedge mclk_i) begin
        if (wr_en_i[g]) begin
          mem[waddr_i] <= wbyte_i;
        end
        rdata_o[(LANES-1-g)*DW +: DW] <= mem[raddr_i];
      end
    end
  endgenerate

endmodule

// File: verilog/rpx_exchange.sv
// command interpreter and result writer between reader and controller
//
// Functional notes
// - command code is word +0 of command area, decoded as BCD.
// - code 0010 starts one read, ending at the first good decode.
// - a failed decode is retried up to the configured retry count.
// - code 0011 starts continuous reading, each result written out.
// - code 0012 ends continuous reading.
// - code 0020 selects scene 0 to 9 from lowest digit of word +1.
// - code 0021 steps scene up, 9 wraps to 0.
// - code 0022 steps scene down, 0 wraps to 9.
// - code 0023 writes flag to +0, scene to low digit of +1.
// - flag digit toggles between 0 and F on every result output.
// - data stored as ASCII, two bytes per word, offsets +1 to +28.
// - at most 56 characters kept; later characters dropped.
// - a failed read puts its error code into word +1.
// - odd byte count pads the last word with space 20.
// - a command left in the area is executed again.
// - command area is polled and executed without handshake.
// - no controller answer within 5 s flags a timeout error.
`timescale 1ns/100ps
`include "rpx_defs.svh"
module rpx_exchange #(
  parameter int unsigned TIMEOUT_CYC = `RPX_TIMEOUT_S * `RPX_CLK_MHZ * 1000000,
  parameter int RETRY_W = 4
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [RETRY_W-1:0] retry_count_i,
  input wire rpx_pkg::rpx_plc_rsp_t plc_rsp_i,
  output rpx_pkg::rpx_plc_req_t plc_req_o,
  input wire rpx_pkg::rpx_dec_in_t dec_i,
  output logic dec_start_o,
  output logic [3:0] scene_o,
  output logic reading_o,
  output logic timeout_err_o
);

  localparam logic [29:0] TMO_LAST = 30'(TIMEOUT_CYC - 1);

  rpx_pkg::rpx_state_t state, next_state;
  rpx_pkg::rpx_kind_t kind, next_kind;
  logic [15:0] wdata, next_wdata;
  logic [15:0] err_code, next_err_code;
  logic [4:0] addr, next_addr;
  logic [4:0] widx, next_widx;
  logic [4:0] nwords, next_nwords;
  logic [5:0] bcnt, next_bcnt;
  logic [RETRY_W-1:0] tries, next_tries;
  logic [29:0] tmo_cnt, next_tmo_cnt;
  logic [3:0] scene, next_scene;
  logic [3:0] flag, next_flag;
  logic cont, next_cont;
  logic tmo_err, next_tmo_err;
  logic start_dec;
  logic [1:0] mem_we;
  logic [15:0] mem_rdata;
  logic req, we, ack;
  logic [15:0] rd;
  logic last_word;

  assign ack = plc_rsp_i.ack;
  assign rd = plc_rsp_i.rdata;
  assign req = (state == rpx_pkg::ST_POLL) || (state == rpx_pkg::ST_ARG) ||
               (state == rpx_pkg::ST_WRITE) || (state == rpx_pkg::ST_FLAG);
  assign we = (state == rpx_pkg::ST_WRITE) || (state == rpx_pkg::ST_FLAG);
  assign last_word = (widx + 5'h01) == nwords;

  // ----------------------------------------
  // result buffer
  // ----------------------------------------
  rpx_result_mem #(
    .DW(8),
    .LANES(2),
    .DEPTH(28),
    .AW(5)
  ) u_mem (
    .mclk_i(mclk_i),
    .wr_en_i(mem_we),
    .waddr_i(bcnt[5:1]),
    .wbyte_i(dec_i.data),
    .raddr_i(widx),
    .rdata_o(mem_rdata)
  );

  // first byte of a pair goes to the high lane
  always_comb begin
    mem_we = 2'b00;
    if (state == rpx_pkg::ST_DECODE && dec_i.byte_valid && bcnt < `RPX_MAX_BYTES) begin
      mem_we = bcnt[0] ? 2'b10 : 2'b01;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_wdata = wdata;
    next_err_code = err_code;
    next_addr = addr;
    next_widx = widx;
    next_nwords = nwords;
    next_bcnt = bcnt;
    next_tries = tries;
    next_tmo_cnt = tmo_cnt;
    next_scene = scene;
    next_flag = flag;
    next_cont = cont;
    next_tmo_err = tmo_err;
    start_dec = 1'b0;
    // a silent controller must not hang the reader
    if (req) begin
      if (ack) begin
        next_tmo_cnt = 30'h0;
        next_tmo_err = 1'b0;
      end else if (tmo_cnt >= TMO_LAST) begin
        next_tmo_cnt = 30'h0;
        next_tmo_err = 1'b1;
        next_state = rpx_pkg::ST_POLL;
        next_addr = `RPX_OFS_CMD;
      end else begin
        next_tmo_cnt = tmo_cnt + 30'h1;
      end
    end
    case (state)
      rpx_pkg::ST_POLL: begin
        if (ack) begin
          next_tries = '0;
          next_bcnt = 6'h0;
          case (rd)
            `RPX_CMD_SINGLE: begin
              start_dec = 1'b1;
              next_state = rpx_pkg::ST_DECODE;
            end
            `RPX_CMD_CONT: begin
              next_cont = 1'b1;
              start_dec = 1'b1;
              next_state = rpx_pkg::ST_DECODE;
            end
            `RPX_CMD_STOP: begin
              next_cont = 1'b0;
            end
            `RPX_CMD_SCENE_SET: begin
              next_state = rpx_pkg::ST_ARG;
              next_addr = `RPX_OFS_ARG;
            end
            `RPX_CMD_SCENE_INC: begin
              next_scene = (scene >= `RPX_SCENE_MAX) ? 4'h0 : scene + 4'h1;
            end
            `RPX_CMD_SCENE_DEC: begin
              next_scene = (scene == 4'h0) ? `RPX_SCENE_MAX : scene - 4'h1;
            end
            `RPX_CMD_SCENE_GET: begin
              next_kind = rpx_pkg::RK_SCENE;
              next_widx = 5'h0;
              next_nwords = 5'h1;
              next_state = rpx_pkg::ST_FETCH;
            end
            default: begin
              // unknown or empty word: only a running continuous read moves on
              if (cont) begin
                start_dec = 1'b1;
                next_state = rpx_pkg::ST_DECODE;
              end
            end
          endcase
        end
      end
      rpx_pkg::ST_ARG: begin
        if (ack) begin
          if (rd[3:0] <= `RPX_SCENE_MAX) begin
            next_scene = rd[3:0];
          end
          next_state = rpx_pkg::ST_POLL;
          next_addr = `RPX_OFS_CMD;
        end
      end
      rpx_pkg::ST_DECODE: begin
        if (dec_i.byte_valid && bcnt < `RPX_MAX_BYTES) begin
          next_bcnt = bcnt + 6'h1;
        end
        if (dec_i.done) begin
          next_widx = 5'h0;
          if (dec_i.ok) begin
            next_kind = rpx_pkg::RK_DATA;
            next_nwords = 5'((bcnt + 6'h1) >> 1);
            next_state = (bcnt == 6'h0) ? rpx_pkg::ST_FLAG : rpx_pkg::ST_FETCH;
            if (bcnt == 6'h0) begin
              next_flag = ~flag;
              next_wdata = {~flag, 12'h000};
              next_addr = `RPX_OFS_FLAG;
            end
          end else if (tries < retry_count_i) begin
            next_tries = tries + 1'b1;
            next_bcnt = 6'h0;
            start_dec = 1'b1;
          end else begin
            next_kind = rpx_pkg::RK_ERR;
            next_err_code = dec_i.err_code;
            next_nwords = 5'h1;
            next_state = rpx_pkg::ST_FETCH;
          end
        end
      end
      rpx_pkg::ST_FETCH: begin
        next_state = rpx_pkg::ST_LOAD;
      end
      rpx_pkg::ST_LOAD: begin
        next_addr = widx + `RPX_OFS_DATA;
        case (kind)
          rpx_pkg::RK_ERR: next_wdata = err_code;
          rpx_pkg::RK_SCENE: next_wdata = {12'h000, scene};
          default: begin
            next_wdata = mem_rdata;
            if (last_word && bcnt[0]) begin
              next_wdata[7:0] = `RPX_PAD_CHAR;
            end
          end
        endcase
        next_state = rpx_pkg::ST_WRITE;
      end
      rpx_pkg::ST_WRITE: begin
        if (ack) begin
          next_widx = widx + 5'h1;
          if (last_word) begin
            // flag goes last so a changed flag means the data is complete
            next_flag = ~flag;
            next_wdata = {~flag, 12'h000};
            next_addr = `RPX_OFS_FLAG;
            next_state = rpx_pkg::ST_FLAG;
          end else begin
            next_state = rpx_pkg::ST_FETCH;
          end
        end
      end
      rpx_pkg::ST_FLAG: begin
        if (ack) begin
          next_addr = `RPX_OFS_CMD;
          next_state = rpx_pkg::ST_POLL;
        end
      end
      default: begin
        next_state = rpx_pkg::ST_POLL;
        next_addr = `RPX_OFS_CMD;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= rpx_pkg::ST_POLL;
      kind <= rpx_pkg::RK_DATA;
      wdata <= 16'h0000;
      err_code <= 16'h0000;
      addr <= `RPX_OFS_CMD;
      widx <= 5'h0;
      nwords <= 5'h0;
      bcnt <= 6'h0;
      tries <= '0;
      tmo_cnt <= 30'h0;
      scene <= `RPX_SCENE_RST;
      flag <= `RPX_FLAG_RST;
      cont <= 1'b0;
      tmo_err <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      wdata <= next_wdata;
      err_code <= next_err_code;
      addr <= next_addr;
      widx <= next_widx;
      nwords <= next_nwords;
      bcnt <= next_bcnt;
      tries <= next_tries;
      tmo_cnt <= next_tmo_cnt;
      scene <= next_scene;
      flag <= next_flag;
      cont <= next_cont;
      tmo_err <= next_tmo_err;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign plc_req_o.req = req;
  assign plc_req_o.we = we;
  assign plc_req_o.area = we ? `RPX_AREA_RES : `RPX_AREA_CMD;
  assign plc_req_o.addr = addr;
  assign plc_req_o.wdata = wdata;
  assign dec_start_o = start_dec;
  assign scene_o = scene;
  assign reading_o = cont;
  assign timeout_err_o = tmo_err;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_cmd(logic [15:0] code);
    state == rpx_pkg::ST_POLL && ack && rd == code;
  endsequence

  sequence s_last_ack;
    state == rpx_pkg::ST_WRITE && ack && last_word;
  endsequence

  property p_poll_word;
    @(posedge mclk_i) disable iff (reset_i)
      state == rpx_pkg::ST_POLL |-> req && !we && plc_req_o.area == `RPX_AREA_CMD && addr == `RPX_OFS_CMD;
  endproperty
  a_poll_word: assert property (p_poll_word) else $error("poll not at command word");

  property p_single;
    @(posedge mclk_i) disable iff (reset_i)
      s_cmd(`RPX_CMD_SINGLE) |-> dec_start_o ##1 state == rpx_pkg::ST_DECODE;
  endproperty
  a_single: assert property (p_single) else $error("single read not started");

  property p_retry;
    @(posedge mclk_i) disable iff (reset_i)
      state == rpx_pkg::ST_DECODE && dec_i.done && !dec_i.ok && tries < retry_count_i
      |-> dec_start_o ##1 (state == rpx_pkg::ST_DECODE && tries == $past(tries) + 1'b1);
  endproperty
  a_retry: assert property (p_retry) else $error("retry missing");

  property p_cont;
    @(posedge mclk_i) disable iff (reset_i)
      s_cmd(`RPX_CMD_CONT) |=> reading_o;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous not set");

  property p_stop;
    @(posedge mclk_i) disable iff (reset_i)
      s_cmd(`RPX_CMD_STOP) |=> !reading_o && state == rpx_pkg::ST_POLL;
  endproperty
  a_stop: assert property (p_stop) else $error("continuous not stopped");

  property p_wrap_up;
    @(posedge mclk_i) disable iff (reset_i)
      s_cmd(`RPX_CMD_SCENE_INC) and (scene == 4'h9) |=> scene_o == 4'h0;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("scene up wrap wrong");

  property p_wrap_down;
    @(posedge mclk_i) disable iff (reset_i)
      s_cmd(`RPX_CMD_SCENE_DEC) and (scene == 4'h0) |=> scene_o == 4'h9;
  endproperty
  a_wrap_down: assert property (p_wrap_down) else $error("scene down wrap wrong");

  property p_flag;
    @(posedge mclk_i) disable iff (reset_i)
      s_last_ack |=> state == rpx_pkg::ST_FLAG && addr == `RPX_OFS_FLAG &&
                     wdata == {~$past(flag), 12'h000};
  endproperty
  a_flag: assert property (p_flag) else $error("write flag not toggled");

  property p_max_bytes;
    @(posedge mclk_i) disable iff (reset_i)
      req && we |-> bcnt <= `RPX_MAX_BYTES && addr <= `RPX_OFS_DATA_LAST;
  endproperty
  a_max_bytes: assert property (p_max_bytes) else $error("byte limit exceeded");

  property p_err_word;
    @(posedge mclk_i) disable iff (reset_i)
      state == rpx_pkg::ST_LOAD && kind == rpx_pkg::RK_ERR |=> wdata == err_code && addr == `RPX_OFS_DATA;
  endproperty
  a_err_word: assert property (p_err_word) else $error("error code misplaced");

  property p_timeout;
    @(posedge mclk_i) disable iff (reset_i)
      req && !ack && tmo_cnt >= TMO_LAST |=> timeout_err_o && state == rpx_pkg::ST_POLL;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

endmodule

// File: tb/rpx_plc_model.sv
// controller memory model answering the exchange's word requests
`timescale 1ns/100ps
module rpx_plc_model (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire rpx_pkg::rpx_plc_req_t req_i,
  input wire logic [3:0] lat_i,
  input wire logic mute_i,
  input wire logic clr_i,
  output rpx_pkg::rpx_plc_rsp_t rsp_o,
  output logic [7:0] flag_cnt_o
);
  // ----------------------------------------
  // memory areas
  // ----------------------------------------
  logic [15:0] cmd [0:1];
  logic [15:0] res [0:31];
  logic [3:0] wait_cnt;

  // ----------------------------------------
  // answer logic
  // ----------------------------------------
  always @(posedge mclk_i) begin
    rsp_o.ack <= 1'b0;
    // released bus never holds its last word
    rsp_o.rdata <= ~rsp_o.rdata;
    if (reset_i) begin
      wait_cnt <= 4'h0;
      flag_cnt_o <= 8'h00;
      rsp_o.rdata <= 16'h0000;
      cmd[0] <= 16'h0000;
      cmd[1] <= 16'h0000;
      for (int k = 1; k < 32; k++) begin
        res[k] <= 16'h0000;
      end
      res[0] <= 16'hf000;
    end else if (req_i.req && !rsp_o.ack && !mute_i) begin
      if (wait_cnt < lat_i) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        wait_cnt <= 4'h0;
        rsp_o.ack <= 1'b1;
        if (req_i.we) begin
          res[req_i.addr] <= req_i.wdata;
          if (req_i.addr == 5'h00) begin
            flag_cnt_o <= flag_cnt_o + 8'h01;
          end
        end else begin
          rsp_o.rdata <= cmd[req_i.addr[0]];
          // ladder clears the command once taken, else it repeats
          if (clr_i && req_i.addr == 5'h00 && cmd[0] != 16'h0000) begin
            cmd[0] <= 16'h0000;
          end
        end
      end
    end
  end
endmodule

// File: tb/rpx_exchange_tb.sv
// self-checking bench for the command and result exchange
`timescale 1ns/100ps
module rpx_exchange_tb;
  logic mclk;
  logic reset;
  logic [3:0] retry;
  rpx_pkg::rpx_plc_rsp_t rsp;
  rpx_pkg::rpx_plc_req_t req;
  rpx_pkg::rpx_dec_in_t dec;
  logic dec_start;
  logic [3:0] scene;
  logic reading;
  logic tmo;
  logic [3:0] lat;
  logic mute;
  logic clr;
  logic [7:0] flag_cnt;
  logic dec_busy;
  int byte_idx;
  int n_bytes;
  int fails_left;
  int start_cnt;
  int mismatches;
  int tests_run;
  int cyc;

  rpx_exchange #(.TIMEOUT_CYC(50), .RETRY_W(4)) u_rpx_exchange (
    .mclk_i(mclk),
    .reset_i(reset),
    .retry_count_i(retry),
    .plc_rsp_i(rsp),
    .plc_req_o(req),
    .dec_i(dec),
    .dec_start_o(dec_start),
    .scene_o(scene),
    .reading_o(reading),
    .timeout_err_o(tmo)
  );

  rpx_plc_model u_rpx_plc_model (
    .mclk_i(mclk),
    .reset_i(reset),
    .req_i(req),
    .lat_i(lat),
    .mute_i(mute),
    .clr_i(clr),
    .rsp_o(rsp),
    .flag_cnt_o(flag_cnt)
  );

  // ----------------------------------------
  // clock, watchdog, decoder stand-in
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  // failed attempts carry no bytes; bytes are A, B, C ... in order
  always @(posedge mclk) begin
    dec.done <= 1'b0;
    dec.byte_valid <= 1'b0;
    if (dec_start) begin
      dec_busy <= 1'b1;
      byte_idx <= 0;
      start_cnt <= start_cnt + 1;
    end else if (dec_busy && fails_left > 0) begin
      dec.done <= 1'b1;
      dec.ok <= 1'b0;
      dec.err_code <= 16'h0e51;
      fails_left <= fails_left - 1;
      dec_busy <= 1'b0;
    end else if (dec_busy && byte_idx < n_bytes) begin
      dec.byte_valid <= 1'b1;
      dec.data <= 8'h41 + byte_idx[7:0];
      byte_idx <= byte_idx + 1;
    end else if (dec_busy) begin
      dec.done <= 1'b1;
      dec.ok <= 1'b1;
      dec_busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic issue(input logic [15:0] code, input logic [15:0] arg);
    @(posedge mclk);
    u_rpx_plc_model.cmd[1] <= arg;
    u_rpx_plc_model.cmd[0] <= code;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 500 && u_rpx_plc_model.cmd[0] != 16'h0000; i++) @(posedge mclk);
    check("command taken", u_rpx_plc_model.cmd[0], 16'h0000);
    repeat (10) @(posedge mclk);
    #1;
  endtask

  task automatic wait_flags(input logic [7:0] n);
    for (int i = 0; i < 3000 && flag_cnt < n; i++) @(posedge mclk);
    #1;
    check("result count", 16'(flag_cnt >= n), 16'h0001);
  endtask

  // flag starts at F and flips on every result
  task automatic chk_flag();
    check("flag word", u_rpx_plc_model.res[0], flag_cnt[0] ? 16'h0000 : 16'hf000);
  endtask

  task automatic run_read(input int nb, input int nf, input logic [3:0] rc);
    logic [7:0] f;
    f = flag_cnt;
    n_bytes = nb;
    fails_left = nf;
    start_cnt = 0;
    @(posedge mclk);
    retry <= rc;
    issue(16'h0010, 16'h0000);
    wait_flags(f + 8'h01);
    chk_flag();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_scene();
    for (int n = 0; n < 10; n++) begin
      issue(16'h0020, n[15:0]);
      check("scene set", scene, n[3:0]);
    end
    issue(16'h0020, 16'h000a);
    check("scene arg 10", scene, 4'h9);
    issue(16'h0099, 16'h0003);
    check("unknown code", {reading, scene}, 5'h09);
    issue(16'h0021, 16'h0000);
    check("scene inc wrap", scene, 4'h0);
    issue(16'h0022, 16'h0000);
    check("scene dec wrap", scene, 4'h9);
    issue(16'h0022, 16'h0000);
    check("scene dec", scene, 4'h8);
    issue(16'h0023, 16'h0000);
    wait_flags(8'h01);
    chk_flag();
    check("scene query", u_rpx_plc_model.res[1], 16'h0008);
    issue(16'h0021, 16'h0000);
    check("scene inc", scene, 4'h9);
  endtask

  task automatic test_reads();
    lat <= 4'h3;
    run_read(3, 1, 4'h2);
    check("retry starts", start_cnt[15:0], 16'h0002);
    check("word 1", u_rpx_plc_model.res[1], 16'h4142);
    check("odd pad", u_rpx_plc_model.res[2], 16'h4320);
    lat <= 4'h0;
    run_read(0, 3, 4'h1);
    check("error starts", start_cnt[15:0], 16'h0002);
    check("error code", u_rpx_plc_model.res[1], 16'h0e51);
    run_read(60, 0, 4'h0);
    for (int k = 1; k <= 28; k++) begin
      check("data word", u_rpx_plc_model.res[k], {8'h3f + 8'(2 * k), 8'h40 + 8'(2 * k)});
    end
    check("beyond 56", u_rpx_plc_model.res[29], 16'h0000);
  endtask

  task automatic test_cont();
    logic [7:0] f;
    n_bytes = 2;
    fails_left = 0;
    f = flag_cnt;
    issue(16'h0011, 16'h0000);
    wait_flags(f + 8'h03);
    check("continuous on", reading, 1'b1);
    check("continuous data", u_rpx_plc_model.res[1], 16'h4142);
    issue(16'h0012, 16'h0000);
    check("continuous off", reading, 1'b0);
    repeat (30) @(posedge mclk);
    f = flag_cnt;
    repeat (200) @(posedge mclk);
    check("no result after stop", flag_cnt, f);
    chk_flag();
  endtask

  task automatic test_repeat();
    logic [7:0] f;
    f = flag_cnt;
    @(posedge mclk);
    clr <= 1'b0;
    u_rpx_plc_model.cmd[0] <= 16'h0023;
    repeat (150) @(posedge mclk);
    u_rpx_plc_model.cmd[0] <= 16'h0000;
    clr <= 1'b1;
    repeat (20) @(posedge mclk);
    check("left command repeats", 16'(flag_cnt - f > 8'h01), 16'h0001);
  endtask

  task automatic test_timeout();
    @(posedge mclk);
    mute <= 1'b1;
    repeat (40) @(posedge mclk);
    #1;
    check("no early timeout", tmo, 1'b0);
    repeat (20) @(posedge mclk);
    #1;
    check("timeout set", tmo, 1'b1);
    check("poll resumes", {req.req, req.we, req.addr}, 7'h40);
    mute <= 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    check("timeout cleared", tmo, 1'b0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    retry = 4'h0;
    dec = '0;
    dec_busy = 1'b0;
    lat = 4'h0;
    mute = 1'b0;
    clr = 1'b1;
    n_bytes = 0;
    fails_left = 0;
    start_cnt = 0;
    mismatches = 0;
    tests_run = 0;
    cyc = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    #1;
    check("reset state", {tmo, reading, scene}, 6'h00);
    check("first poll", {req.req, req.we, req.area, req.addr}, 8'h80);
    test_scene();
    test_reads();
    test_cont();
    test_repeat();
    test_timeout();
    end_sim();
  end
endmodule
